// ### tsr_pkg.sv
`default_nettype none
package tsr_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_KHZ          = 250000;   // 250 MHz core clock
  localparam int HALF_SECOND_MS   = 500;      // Timer toggle interval
  localparam int LOS_HOLD_US      = 1000;     // Low level persistence before loss
  localparam int PHASE_SAMPLE_US  = 250;      // Phase count refresh interval
  localparam int HALF_SECOND_CYC  = HALF_SECOND_MS * CLK_KHZ;
  localparam int LOS_HOLD_CYC     = (LOS_HOLD_US * CLK_KHZ) / 1000;
  localparam int PHASE_SAMPLE_CYC = (PHASE_SAMPLE_US * CLK_KHZ) / 1000;

  // Half-second ticks per full cycle of the five-second timer
  localparam logic [3:0] TICK_WRAP      = 4'h9;
  localparam logic [3:0] FIVE_TICK_A    = 4'h4;
  localparam logic [3:0] FIVE_TICK_B    = 4'h9;

  // ==========================================================================
  // Message persistence filter
  // ==========================================================================
  localparam int         MSG_WINDOW = 10;
  localparam logic [3:0] MSG_NEEDED = 4'h8;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [3:0] PAGE_CTRL   = 4'h1;
  localparam logic [3:0] PAGE_STATUS = 4'h3;
  localparam logic [4:0] OFS_TIMER   = 5'h12;
  localparam logic [4:0] OFS_RX_HIGH = 5'h13;
  localparam logic [4:0] OFS_RX_LOW  = 5'h14;
  localparam logic [4:0] OFS_MSG     = 5'h15;
  localparam logic [4:0] OFS_LINE    = 5'h16;
  localparam logic [4:0] OFS_TX_SLIP = 5'h17;
  localparam logic [4:0] OFS_TX_DLY  = 5'h17;  // Control page, write clears depth bit
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic       sel;
    logic       rd;
    logic       wr;
    logic [3:0] page;
    logic [4:0] addr;
  } tsr_bus_s;

  typedef struct packed {
    logic [4:0] slot;
    logic [2:0] bit_cnt;
    logic [2:0] sub;
    logic       over;
  } tsr_phase_s;

  typedef struct packed {
    logic ev;
    logic rep;
  } tsr_slip_s;

endpackage : tsr_pkg
`default_nettype wire

// ### tsr_msg_filter.sv
`timescale 1ns/10ps
`default_nettype none
module tsr_msg_filter (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       cw_valid,
  input  wire logic [7:0] cw,
  output var  logic [7:0] msg
);
  import tsr_pkg::*;

  typedef struct packed {
    logic [7:0]            cand;
    logic [MSG_WINDOW-1:0] hist;
    logic [7:0]            msg;
  } tsr_filt_s;

  tsr_filt_s st_reg;
  tsr_filt_s st_next;
  logic [MSG_WINDOW-1:0] hist_new;

  // ==========================================================================
  // Persistence: a candidate counts its unbroken run of hits, capped at ten positions
  // ==========================================================================
  always_comb begin
    st_next  = st_reg;
    hist_new = {st_reg.hist[MSG_WINDOW-2:0], 1'b1};
    if (cw_valid) begin
      if (cw == st_reg.cand) begin
        st_next.hist = hist_new;
        // Load only once a new word is seen often enough [RULE_11]
        if (4'($countones(hist_new)) >= MSG_NEEDED) begin
          st_next.msg = cw;
        end
      end else begin
        // A different word starts its own count; old hits do not carry over
        st_next.cand = cw;
        st_next.hist = {{(MSG_WINDOW-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign msg = st_reg.msg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_msg_needs_hits: assert property ($changed(msg) |-> // [RULE_11]
      $past(cw_valid) && $past(cw) == msg && $countones($past(st_reg.hist)) >= 7)
    else $error("message byte loaded without enough repeats");

endmodule : tsr_msg_filter
`default_nettype wire

// ### tsr_status_regs.sv
// What this block does
// (RULE_01) One-second timer bit toggles every half second.
// (RULE_02) Two-second timer bit toggles every second, aligned with one-second bit.
// (RULE_03) Five-second timer bit toggles every 2.5 s, aligned with one-second bit.
// (RULE_04) Receive slip bit 7 toggles on each receive controlled frame slip.
// (RULE_05) Receive slip direction: one for repeated frame, zero for lost frame.
// (RULE_06) Receive depth bit is one when buffer delay exceeds one frame.
// (RULE_07) Receive frame wink bit toggles on falling edge of slot count MSB.
// (RULE_08) Sub-bit depth in three bits: clock, half clock, eighth clock.
// (RULE_09) Five-bit timeslot phase count in bits 7-3, refreshed every 250 us.
// (RULE_10) Three-bit bit-time phase count in bits 2-0, refreshed every 250 us.
// (RULE_11) Message byte loads after a new codeword appears in 8 of 10; the code needs 8 in a row, any other word restarts the count.
// (RULE_12) Line loss bit high after low level lasts 1 ms, else low.
// (RULE_13) Transmit slip bit 7 toggles on each transmit controlled frame slip.
// (RULE_14) Transmit slip direction: one for repeated frame, zero for lost frame.
// (RULE_15) Transmit depth bit is one when transmit buffer delay exceeds one frame.
// (RULE_16) Writing the transmit slip delay register clears the transmit depth bit.
// (RULE_17) Unused bits read zero; writes to these status registers are ignored.
`timescale 1ns/10ps
`default_nettype none
module tsr_status_regs #(
  parameter int HALF_SECOND_CYCLES = tsr_pkg::HALF_SECOND_CYC,
  parameter int LOS_HOLD_CYCLES    = tsr_pkg::LOS_HOLD_CYC,
  parameter int PHASE_SAMPLE_CYCLES = tsr_pkg::PHASE_SAMPLE_CYC
) (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire tsr_pkg::tsr_bus_s  bus,
  output var  logic [7:0]         rdata,
  input  wire tsr_pkg::tsr_phase_s rx_phase,
  input  wire tsr_pkg::tsr_slip_s rx_slip,
  input  wire tsr_pkg::tsr_slip_s tx_slip,
  input  wire logic               tx_over_frame,
  input  wire logic               cw_valid,
  input  wire logic [7:0]         cw,
  input  wire logic               line_level_low
);
  import tsr_pkg::*;

  typedef struct packed {
    logic        lvl_meta;
    logic        lvl_sync;
    logic [26:0] sec_cnt;
    logic [3:0]  tick_cnt;
    logic        one_s;
    logic        two_s;
    logic        five_s;
    logic        rx_slip_tgl;
    logic        rx_dir;
    logic        rx_over;
    logic        rx_wink;
    logic        slot_msb_d;
    logic [2:0]  rx_sub;
    logic [15:0] samp_cnt;
    logic [4:0]  rx_slot;
    logic [2:0]  rx_bit;
    logic [17:0] los_cnt;
    logic        los;
    logic        tx_slip_tgl;
    logic        tx_dir;
    logic        tx_over;
    logic        tx_over_d;
    logic [7:0]  rdata;
  } tsr_state_s;

  tsr_state_s st_reg;
  tsr_state_s st_next;
  logic [7:0] msg_byte;
  logic       half_tick;
  logic       sample_tick;
  logic       delay_write;
  logic       status_read;

  // ==========================================================================
  // Message byte filter
  // ==========================================================================
  tsr_msg_filter u_msg (
    .clk      (clk),
    .reset    (reset),
    .cw_valid (cw_valid),
    .cw       (cw),
    .msg      (msg_byte)
  );

  // Strobes decoded from the counters and the processor port
  assign half_tick   = (st_reg.sec_cnt == 27'(HALF_SECOND_CYCLES - 1));
  assign sample_tick = (st_reg.samp_cnt == 16'(PHASE_SAMPLE_CYCLES - 1));
  assign delay_write = bus.sel && bus.wr && bus.page == PAGE_CTRL && bus.addr == OFS_TX_DLY;
  assign status_read = bus.sel && bus.rd && bus.page == PAGE_STATUS;

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    st_next = st_reg;

    // Level pin crosses in through two flops before anything reads it
    st_next.lvl_meta = line_level_low;
    st_next.lvl_sync = st_reg.lvl_meta;

    // Free-running half-second base; all timers step on the same tick
    st_next.sec_cnt = half_tick ? 27'h0 : st_reg.sec_cnt + 27'h1;
    if (half_tick) begin
      st_next.tick_cnt = (st_reg.tick_cnt == TICK_WRAP) ? 4'h0 : st_reg.tick_cnt + 4'h1;
      st_next.one_s    = ~st_reg.one_s;                                   // [RULE_01]
      if (st_reg.tick_cnt[0]) begin
        st_next.two_s = ~st_reg.two_s;                                    // [RULE_02]
      end
      if (st_reg.tick_cnt == FIVE_TICK_A || st_reg.tick_cnt == FIVE_TICK_B) begin
        st_next.five_s = ~st_reg.five_s;                                  // [RULE_03]
      end
    end

    // Receive slip history
    if (rx_slip.ev) begin
      st_next.rx_slip_tgl = ~st_reg.rx_slip_tgl;                          // [RULE_04]
      st_next.rx_dir      = rx_slip.rep;                                  // [RULE_05]
    end
    st_next.rx_over    = rx_phase.over;                                   // [RULE_06]
    st_next.rx_sub     = rx_phase.sub;                                    // [RULE_08]
    st_next.slot_msb_d = rx_phase.slot[4];
    if (st_reg.slot_msb_d && !rx_phase.slot[4]) begin
      st_next.rx_wink = ~st_reg.rx_wink;                                  // [RULE_07]
    end

    // Phase counts are snapshots, so software sees a stable pair between refreshes
    st_next.samp_cnt = sample_tick ? 16'h0 : st_reg.samp_cnt + 16'h1;
    if (sample_tick) begin
      st_next.rx_slot = rx_phase.slot;                                    // [RULE_09]
      st_next.rx_bit  = rx_phase.bit_cnt;                                 // [RULE_10]
    end

    // Loss of signal needs the low level to persist; any recovery restarts the wait
    if (!st_reg.lvl_sync) begin
      st_next.los_cnt = 18'h0;
      st_next.los     = 1'b0;                                             // [RULE_12]
    end else if (st_reg.los_cnt == 18'(LOS_HOLD_CYCLES - 1)) begin
      st_next.los     = 1'b1;                                             // [RULE_12]
    end else begin
      st_next.los_cnt = st_reg.los_cnt + 18'h1;
    end

    // Transmit slip history
    if (tx_slip.ev) begin
      st_next.tx_slip_tgl = ~st_reg.tx_slip_tgl;                          // [RULE_13]
      st_next.tx_dir      = tx_slip.rep;                                  // [RULE_14]
    end
    // Depth follows the buffer; a delay write clears it until the buffer reasserts.
    // A rise in the same cycle as the write wins, so the event is not lost.
    st_next.tx_over_d = tx_over_frame;
    if (tx_over_frame && !st_reg.tx_over_d) begin
      st_next.tx_over = 1'b1;                                             // [RULE_15]
    end else if (delay_write) begin
      st_next.tx_over = 1'b0;                                             // [RULE_16]
    end else if (!tx_over_frame) begin
      st_next.tx_over = 1'b0;                                             // [RULE_15]
    end

    // Read port: data stands until the next read; writes here change nothing
    if (status_read) begin
      unique case (bus.addr)
        OFS_TIMER:   st_next.rdata = {st_reg.one_s, st_reg.two_s, st_reg.five_s, 5'h00};
        OFS_RX_HIGH: st_next.rdata = {st_reg.rx_slip_tgl, st_reg.rx_dir, st_reg.rx_over,
                                      1'b0, st_reg.rx_wink, st_reg.rx_sub};
        OFS_RX_LOW:  st_next.rdata = {st_reg.rx_slot, st_reg.rx_bit};
        OFS_MSG:     st_next.rdata = msg_byte;
        OFS_LINE:    st_next.rdata = {st_reg.los, 7'h00};
        OFS_TX_SLIP: st_next.rdata = {st_reg.tx_slip_tgl, st_reg.tx_dir, st_reg.tx_over, 5'h00};
        default:     st_next.rdata = 8'h00;                               // [RULE_17]
      endcase
    end else if (bus.sel && bus.rd) begin
      st_next.rdata = 8'h00;                                              // [RULE_17]
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg       <= '0;
      st_reg.rdata <= RDATA_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_one_second_tick: assert property (half_tick |=> $changed(st_reg.one_s)) // [RULE_01]
    else $error("one-second bit missed its tick");

  chk_two_second_align: assert property ($changed(st_reg.two_s) |-> // [RULE_02]
      $changed(st_reg.one_s) && st_reg.one_s == 1'b0)
    else $error("two-second bit moved off the one-second edge");

  chk_five_second_align: assert property ($changed(st_reg.five_s) |-> // [RULE_03]
      $changed(st_reg.one_s) && (st_reg.tick_cnt == 4'h5 || st_reg.tick_cnt == 4'h0))
    else $error("five-second bit moved off its tick");

  chk_rx_slip_record: assert property (rx_slip.ev |=> // [RULE_05]
      $changed(st_reg.rx_slip_tgl) && st_reg.rx_dir == $past(rx_slip.rep))
    else $error("receive slip not recorded");

  chk_rx_wink_edge: assert property ($fell(rx_phase.slot[4]) ##1 1'b1 |-> // [RULE_07]
      $changed(st_reg.rx_wink))
    else $error("frame wink did not toggle");

  chk_phase_hold: assert property (!sample_tick |=> $stable(st_reg.rx_slot)) // [RULE_09]
    else $error("slot phase count moved between refreshes");

  chk_los_rise: assert property ($rose(st_reg.los) |-> // [RULE_12]
      $past(st_reg.los_cnt) == 18'(LOS_HOLD_CYCLES - 1) && $past(st_reg.lvl_sync))
    else $error("loss of signal set too early");

  chk_tx_slip_record: assert property (tx_slip.ev |=> // [RULE_14]
      $changed(st_reg.tx_slip_tgl) && st_reg.tx_dir == $past(tx_slip.rep))
    else $error("transmit slip not recorded");

  chk_tx_depth_clear: assert property (delay_write && !(tx_over_frame && !st_reg.tx_over_d) // [RULE_16]
      |=> !st_reg.tx_over)
    else $error("transmit depth bit survived a delay write");

  chk_unmapped_zero: assert property (bus.sel && bus.rd && bus.page != PAGE_STATUS // [RULE_17]
      |=> rdata == 8'h00)
    else $error("read outside the status page returned data");

  // ==========================================================================
  // Checks on live and loaded bits, on quiet cycles and on unused read bits
  // ==========================================================================
  chk_rx_depth_live: assert property (1'b1 |=> // [RULE_06]
      st_reg.rx_over == $past(rx_phase.over))
    else $error("receive depth bit lagged the buffer");

  chk_rx_sub_live: assert property (1'b1 |=> // [RULE_08]
      st_reg.rx_sub == $past(rx_phase.sub))
    else $error("sub-bit depth lagged the buffer");

  chk_slot_load: assert property (sample_tick |=> // [RULE_09]
      st_reg.rx_slot == $past(rx_phase.slot))
    else $error("slot phase count not loaded on refresh");

  chk_rx_bit_load: assert property (sample_tick |=> // [RULE_10]
      st_reg.rx_bit == $past(rx_phase.bit_cnt))
    else $error("bit phase count not loaded on refresh");

  chk_rx_slip_quiet: assert property (!rx_slip.ev |=> // [RULE_04]
      $stable(st_reg.rx_slip_tgl) && $stable(st_reg.rx_dir))
    else $error("receive slip bits moved without a slip");

  chk_tx_slip_quiet: assert property (!tx_slip.ev |=> // [RULE_13]
      $stable(st_reg.tx_slip_tgl) && $stable(st_reg.tx_dir))
    else $error("transmit slip bits moved without a slip");

  chk_tx_depth_set: assert property (tx_over_frame && !st_reg.tx_over_d |=> // [RULE_15]
      st_reg.tx_over)
    else $error("transmit depth bit missed a rise");

  chk_tx_depth_drop: assert property (!tx_over_frame |=> // [RULE_15]
      !st_reg.tx_over)
    else $error("transmit depth bit stayed up below one frame");

  chk_los_clear: assert property (!st_reg.lvl_sync |=> // [RULE_12]
      !st_reg.los)
    else $error("loss of signal stayed up at normal level");

  chk_wink_quiet: assert property (!(st_reg.slot_msb_d && !rx_phase.slot[4]) |=> // [RULE_07]
      $stable(st_reg.rx_wink))
    else $error("frame wink toggled without a falling edge");

  chk_timer_quiet: assert property (!half_tick |=> // [RULE_01]
      $stable(st_reg.one_s) && $stable(st_reg.two_s) && $stable(st_reg.five_s))
    else $error("timer bits moved between ticks");

  chk_rdata_hold: assert property (!(bus.sel && bus.rd) |=> // [RULE_17]
      $stable(rdata))
    else $error("read data moved without a read");

  chk_line_read: assert property (status_read && bus.addr == OFS_LINE |=> // [RULE_12]
      rdata == {$past(st_reg.los), 7'h00})
    else $error("line status read returned wrong data");

  chk_timer_gap: assert property (status_read && bus.addr == OFS_TIMER |=> // [RULE_17]
      rdata[4:0] == 5'h00)
    else $error("unused timer bits read nonzero");

  chk_tx_gap: assert property (status_read && bus.addr == OFS_TX_SLIP |=> // [RULE_17]
      rdata[4:0] == 5'h00)
    else $error("unused transmit slip bits read nonzero");

  chk_rx_high_gap: assert property (status_read && bus.addr == OFS_RX_HIGH |=> // [RULE_17]
      rdata[4] == 1'b0)
    else $error("unused receive phase bit read nonzero");

endmodule : tsr_status_regs
`default_nettype wire

// ### test_t1_slip_timer_status_regs.sv
`timescale 1ns/10ps
`default_nettype none
// Counts every compare and reports a mismatch at once
`define CHK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("unexpected at %0t: read %h, wanted %h", $time, got, exp); \
  end \
end
module test_t1_slip_timer_status_regs;
  import tsr_pkg::*;
  // Shortened counts keep the whole run to a few hundred cycles
  localparam int HALF  = 20;
  localparam int LOSH  = 10;
  localparam int SAMP  = 8;
  localparam int LIMIT = 2000;

  logic       clk;
  logic       reset;
  tsr_bus_s   bus;
  logic [7:0] rdata;
  tsr_phase_s rx_phase;
  tsr_slip_s  rx_slip;
  tsr_slip_s  tx_slip;
  logic       tx_over_frame;
  logic       cw_valid;
  logic [7:0] cw;
  logic       line_level_low;
  int         errors      = 0;
  int         comparisons = 0;
  int         cyc         = 0;
  int         rel;
  logic       rx_tog      = 1'b0;
  logic       rx_dir      = 1'b0;
  logic       tx_tog      = 1'b0;
  logic       tx_dir      = 1'b0;

  tsr_status_regs #(
    .HALF_SECOND_CYCLES  (HALF),
    .LOS_HOLD_CYCLES     (LOSH),
    .PHASE_SAMPLE_CYCLES (SAMP)
  ) dut (
    .clk            (clk),
    .reset          (reset),
    .bus            (bus),
    .rdata          (rdata),
    .rx_phase       (rx_phase),
    .rx_slip        (rx_slip),
    .tx_slip        (tx_slip),
    .tx_over_frame  (tx_over_frame),
    .cw_valid       (cw_valid),
    .cw             (cw),
    .line_level_low (line_level_low)
  );

  // ==========================================================================
  // Clock, cycle count and hang guard
  // ==========================================================================
  initial clk = 1'b0;
  always #2 clk = ~clk;

  // A stuck sequence is cut short and counted as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      errors++;
      summarize();
    end
  end

  // ==========================================================================
  // Port tasks
  // ==========================================================================
  task automatic summarize();
    if (errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  // Read answer lands on the same edge that takes the strobe
  task automatic read_reg(input logic [3:0] page, input logic [4:0] addr, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{sel: 1'b1, rd: 1'b1, wr: 1'b0, page: page, addr: addr};
    @(posedge clk);
    bus <= '0;
    #1;
    `CHK(rdata, exp)
  endtask : read_reg

  task automatic write_reg(input logic [3:0] page, input logic [4:0] addr);
    @(posedge clk);
    bus <= '{sel: 1'b1, rd: 1'b0, wr: 1'b1, page: page, addr: addr};
    @(posedge clk);
    bus <= '0;
  endtask : write_reg

  // n back-to-back slip pulses of one direction; model tracks toggle and direction
  task automatic slip(input logic tx, input logic rep, input int n);
    @(posedge clk);
    if (tx) begin
      tx_slip <= '{ev: 1'b1, rep: rep};
      tx_tog = tx_tog ^ n[0];
      tx_dir = rep;
    end else begin
      rx_slip <= '{ev: 1'b1, rep: rep};
      rx_tog = rx_tog ^ n[0];
      rx_dir = rep;
    end
    repeat (n) @(posedge clk);
    tx_slip <= '0;
    rx_slip <= '0;
  endtask : slip

  // Codeword positions spaced by an idle cycle, as on a real link
  task automatic words(input logic [7:0] w, input int n);
    repeat (n) begin
      @(posedge clk);
      cw_valid <= 1'b1;
      cw       <= w;
      @(posedge clk);
      cw_valid <= 1'b0;
    end
  endtask : words

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    reset          = 1'b1;
    bus            = '0;
    rx_phase       = '0;
    rx_slip        = '0;
    tx_slip        = '0;
    tx_over_frame  = 1'b0;
    cw_valid       = 1'b0;
    cw             = 8'h00;
    line_level_low = 1'b0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rel = cyc;
    // Sample mid-interval so the read latency cannot straddle a tick
    for (int k = 0; k <= 10; k++) begin
      while (cyc < rel + HALF * k + HALF / 2) @(posedge clk);
      read_reg(PAGE_STATUS, OFS_TIMER, {k[0], k[1], (k / 5) % 2 == 1, 5'h00});
    end
    // Slot MSB falls once, so the wink bit must have flipped
    @(posedge clk) rx_phase <= '{slot: 5'h13, bit_cnt: 3'h6, sub: 3'h5, over: 1'b1};
    @(posedge clk) rx_phase.slot <= 5'h03;
    repeat (2 * SAMP) @(posedge clk);
    read_reg(PAGE_STATUS, OFS_RX_LOW, 8'h1e);
    slip(1'b0, 1'b1, 1);
    read_reg(PAGE_STATUS, OFS_RX_HIGH, {rx_tog, rx_dir, 6'h2d});
    slip(1'b0, 1'b0, 2);
    read_reg(PAGE_STATUS, OFS_RX_HIGH, {rx_tog, rx_dir, 6'h2d});
    @(posedge clk) rx_phase <= '{slot: 5'h03, bit_cnt: 3'h6, sub: 3'h2, over: 1'b0};
    slip(1'b0, 1'b0, 1);
    write_reg(PAGE_STATUS, OFS_RX_HIGH);
    read_reg(PAGE_STATUS, OFS_RX_HIGH, {rx_tog, rx_dir, 6'h0a});
    // Transmit side: a status-page write leaves the depth bit set, the control-page write clears it
    @(posedge clk) tx_over_frame <= 1'b1;
    slip(1'b1, 1'b1, 1);
    write_reg(PAGE_STATUS, OFS_TX_SLIP);
    read_reg(PAGE_STATUS, OFS_TX_SLIP, {tx_tog, tx_dir, 6'h20});
    write_reg(PAGE_CTRL, OFS_TX_DLY);
    slip(1'b1, 1'b0, 2);
    read_reg(PAGE_STATUS, OFS_TX_SLIP, {tx_tog, tx_dir, 6'h00});
    @(posedge clk) tx_over_frame <= 1'b0;
    @(posedge clk) tx_over_frame <= 1'b1;
    slip(1'b1, 1'b0, 1);
    read_reg(PAGE_STATUS, OFS_TX_SLIP, {tx_tog, tx_dir, 6'h20});
    // Message byte: seven sightings are not enough, the eighth loads
    read_reg(PAGE_STATUS, OFS_MSG, 8'h00);
    words(8'ha5, 7);
    read_reg(PAGE_STATUS, OFS_MSG, 8'h00);
    words(8'ha5, 1);
    read_reg(PAGE_STATUS, OFS_MSG, 8'ha5);
    words(8'h3c, 7);
    words(8'h11, 7);
    read_reg(PAGE_STATUS, OFS_MSG, 8'ha5);
    words(8'h11, 1);
    read_reg(PAGE_STATUS, OFS_MSG, 8'h11);
    // A short low-level blip must not raise loss; a sustained one must
    @(posedge clk) line_level_low <= 1'b1;
    repeat (LOSH / 2) @(posedge clk);
    line_level_low <= 1'b0;
    repeat (2 * LOSH) @(posedge clk);
    read_reg(PAGE_STATUS, OFS_LINE, 8'h00);
    line_level_low <= 1'b1;
    repeat (LOSH - 2) @(posedge clk);
    read_reg(PAGE_STATUS, OFS_LINE, 8'h00);
    repeat (LOSH) @(posedge clk);
    read_reg(PAGE_STATUS, OFS_LINE, 8'h80);
    @(posedge clk) line_level_low <= 1'b0;
    repeat (5) @(posedge clk);
    read_reg(PAGE_STATUS, OFS_LINE, 8'h00);
    // Unmapped address and foreign page read as zero
    read_reg(PAGE_STATUS, 5'h1a, 8'h00);
    read_reg(4'h2, OFS_TIMER, 8'h00);
    summarize();
  end
endmodule : test_t1_slip_timer_status_regs
`undef CHK
`default_nettype wire
